// ### rtl/ipecd_cfg.svh
// Constants for the port expander change-detect block
`ifndef IPECD_CFG_SVH
`define IPECD_CFG_SVH

// Fixed upper slave address bits per port group
`define IPECD_GRPA_PREFIX 3'h6
`define IPECD_GRPB_PREFIX 3'h5
// Bits in a byte on the serial link
`define IPECD_BYTE_BITS 4'h8
// Sys cycles after reset before the strap pins are read
`define IPECD_STRAP_WAIT 2'h3
// Reset values and strap nibble values
`define IPECD_MASK_RST 4'h0
`define IPECD_OUTA_RST 4'h0
`define IPECD_OUTB_RST 8'hFF
`define IPECD_NIB_HI 4'hF
`define IPECD_NIB_LO 4'h0
// Input field within a group A data byte
`define IPECD_IN_MSB 5
`define IPECD_IN_LSB 2
// Address code of the high select pin (address bits 3..2)
`define IPECD_HI_SCL 2'h0
`define IPECD_HI_SDA 2'h1
`define IPECD_HI_GND 2'h2
`define IPECD_HI_VCC 2'h3
// Address code of the low select pin (address bits 1..0)
`define IPECD_LO_GND 2'h0
`define IPECD_LO_VCC 2'h1
`define IPECD_LO_SCL 2'h2
`define IPECD_LO_SDA 2'h3

`endif

// ### rtl/ipecd_pkg.sv
// Types for the port expander change-detect block
package ipecd_pkg;

	// ----------------------------------------
	// Select pin connection
	// ----------------------------------------
	typedef enum logic [1:0] {
		LVL_GND = 2'h0,
		LVL_VCC = 2'h1,
		LVL_SCL = 2'h2,
		LVL_SDA = 2'h3
	} ipecd_level_t;

	// ----------------------------------------
	// Requests from link domain to port domain
	// ----------------------------------------
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_ADDR_RD = 3'h1,
		CMD_ADDR_WR = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_NEXT = 3'h4,
		CMD_STOP = 3'h5
	} ipecd_cmd_t;

	typedef struct packed {
		ipecd_cmd_t cmd;
		logic grpB;
		logic [7:0] data;
	} ipecd_req_t;

	// ----------------------------------------
	// Link state machine
	// ----------------------------------------
	typedef enum logic [2:0] {
		LK_IDLE = 3'h0,
		LK_ADDR = 3'h1,
		LK_AACK = 3'h2,
		LK_RX = 3'h3,
		LK_RACK = 3'h4,
		LK_TX = 3'h5,
		LK_MACK = 3'h6,
		LK_WAIT = 3'h7
	} ipecd_lstate_t;

endpackage

// ### rtl/ipecd_sel_decode.sv
// Classifies a four-level address select pin during a frame
`timescale 1ns/1ps
module ipecd_sel_decode (
	input wire logic linkClk,
	input wire logic linkRst_n,
	input wire logic frameStart,
	input wire logic pinLevel,
	input wire logic sclLevel,
	input wire logic sdaLevel,
	output ipecd_pkg::ipecd_level_t level
);

	logic eqScl_reg;
	logic eqSda_reg;
	logic seenLow_reg;

	// ----------------------------------------
	// Track pin against the bus lines
	// ----------------------------------------
	always_ff @(posedge linkClk) begin
		if (!linkRst_n) begin
			eqScl_reg <= 1'b1;
			eqSda_reg <= 1'b1;
			seenLow_reg <= 1'b0;
		end else if (frameStart) begin
			eqScl_reg <= 1'b1;
			eqSda_reg <= 1'b1;
			seenLow_reg <= ~pinLevel;
		end else begin
			if (pinLevel != sclLevel) begin
				eqScl_reg <= 1'b0;
			end
			if (pinLevel != sdaLevel) begin
				eqSda_reg <= 1'b0;
			end
			if (!pinLevel) begin
				seenLow_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Connection from what was seen
	// ----------------------------------------
	always_comb begin
		if (!seenLow_reg) begin
			level = ipecd_pkg::LVL_VCC;
		end else if (eqScl_reg) begin
			level = ipecd_pkg::LVL_SCL;
		end else if (eqSda_reg) begin
			level = ipecd_pkg::LVL_SDA;
		end else begin
			level = ipecd_pkg::LVL_GND;
		end
	end

endmodule

// ### rtl/ipecd_core.sv
// Serial port expander with input change detection and interrupt
// Operation
// RULE_01 - Snapshot of four inputs compared continuously; mismatch sets flag
// RULE_02 - Every access acknowledge relatches snapshot and clears old flags
// RULE_03 - Two-byte group A read sends pre-clear flags as second byte
// RULE_04 - Longer reads alternate data and flags, relatching each pair
// RULE_05 - Four-bit mask chooses which inputs may interrupt
// RULE_06 - Flags set regardless of mask; mask gates interrupt only
// RULE_07 - No interrupt during a read; deferred change raises it at stop
// RULE_08 - No deferred interrupt when changed data was already sent
// RULE_09 - Flag stays set until next clearing access
// RULE_10 - Flags readable and mask writable over the serial link
// RULE_11 - Data line is input and open-drain output; clock only input
// RULE_12 - The master starts every transfer and makes the clock
// RULE_13 - Start, address with direction, data bytes, then stop
// RULE_14 - Lines idle high; start and stop are data edges, clock high
// RULE_15 - One bit per clock pulse, data steady while clock high
// RULE_16 - Ninth clock is acknowledge; receiver holds data low
// RULE_17 - Device acknowledges received bytes; master acknowledges sent ones
// RULE_18 - Two slave addresses, one per group; eighth bit is direction
// RULE_19 - Top address bits 110 for group A, 101 for group B
// RULE_20 - Select pins give 16 addresses by four-level coding
// RULE_21 - Group B outputs start low per nibble when its select pin grounded
// RULE_22 - Interrupt released during address acknowledge of an access
// RULE_23 - Group A write bytes acknowledged and update outputs and mask
// RULE_24 - Master not acknowledging takes no snapshot, keeps interrupt state
// RULE_25 - Group B read returns pin levels, resampled each acknowledge
// RULE_26 - Interrupt asserted when any enabled flag is set
// RULE_27 - Byte bit n maps to port n of the group
`timescale 1ns/1ps
`include "ipecd_cfg.svh"
module ipecd_core (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic linkClk,
	input wire logic linkRst_n,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	output logic intOut,
	output logic intOeN,
	input wire logic addrSelHighPin,
	input wire logic addrSelLowPin,
	input wire logic [3:0] monitoredInputs,
	input wire logic [3:0] groupAPinLevel,
	input wire logic [7:0] groupBPinLevel,
	output logic [3:0] groupAOut,
	output logic [7:0] outputGroupB,
	output logic [3:0] changeFlags,
	output logic [3:0] interruptMask
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [1:0] hiCode(ipecd_pkg::ipecd_level_t l);
		unique case (l)
			ipecd_pkg::LVL_SCL: hiCode = `IPECD_HI_SCL;
			ipecd_pkg::LVL_SDA: hiCode = `IPECD_HI_SDA;
			ipecd_pkg::LVL_GND: hiCode = `IPECD_HI_GND;
			ipecd_pkg::LVL_VCC: hiCode = `IPECD_HI_VCC;
		endcase
	endfunction

	function automatic logic [1:0] loCode(ipecd_pkg::ipecd_level_t l);
		unique case (l)
			ipecd_pkg::LVL_GND: loCode = `IPECD_LO_GND;
			ipecd_pkg::LVL_VCC: loCode = `IPECD_LO_VCC;
			ipecd_pkg::LVL_SCL: loCode = `IPECD_LO_SCL;
			ipecd_pkg::LVL_SDA: loCode = `IPECD_LO_SDA;
		endcase
	endfunction

	function automatic ipecd_pkg::ipecd_req_t mkReq(
		ipecd_pkg::ipecd_cmd_t c, logic g, logic [7:0] d);
		mkReq.cmd = c;
		mkReq.grpB = g;
		mkReq.data = d;
	endfunction

	// ----------------------------------------
	// Link domain: synchronisers and edges
	// ----------------------------------------
	logic [1:0] sclSync_reg;
	logic [1:0] sdaSync_reg;
	logic [1:0] hiLkSync_reg;
	logic [1:0] loLkSync_reg;
	logic [1:0] rplSync_reg;
	logic rplTgl_reg;
	logic sclPrev_reg;
	logic sdaPrev_reg;
	logic rplPrev_reg;
	logic scl;
	logic sda;
	logic sclRise;
	logic sclFall;
	logic startDet;
	logic stopDet;

	always_ff @(posedge linkClk) begin
		if (!linkRst_n) begin
			sclSync_reg <= 2'h3;
			sdaSync_reg <= 2'h3;
			hiLkSync_reg <= 2'h3;
			loLkSync_reg <= 2'h3;
			rplSync_reg <= 2'h0;
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
			rplPrev_reg <= 1'b0;
		end else begin
			sclSync_reg <= {sclSync_reg[0], sclIn}; // [RULE_11]
			sdaSync_reg <= {sdaSync_reg[0], sdaIn};
			hiLkSync_reg <= {hiLkSync_reg[0], addrSelHighPin};
			loLkSync_reg <= {loLkSync_reg[0], addrSelLowPin};
			rplSync_reg <= {rplSync_reg[0], rplTgl_reg};
			sclPrev_reg <= sclSync_reg[1];
			sdaPrev_reg <= sdaSync_reg[1];
			rplPrev_reg <= rplSync_reg[1];
		end
	end

	assign scl = sclSync_reg[1];
	assign sda = sdaSync_reg[1];
	assign sclRise = ~sclPrev_reg & scl; // [RULE_15]
	assign sclFall = sclPrev_reg & ~scl;
	assign startDet = sclPrev_reg & scl & sdaPrev_reg & ~sda; // [RULE_14]
	assign stopDet = sclPrev_reg & scl & ~sdaPrev_reg & sda; // [RULE_14]

	// ----------------------------------------
	// Link domain: slave address
	// ----------------------------------------
	ipecd_pkg::ipecd_level_t hiLevel;
	ipecd_pkg::ipecd_level_t loLevel;
	logic [3:0] selBits;
	logic matchA;
	logic matchB;

	ipecd_sel_decode u_hiSel (
		.linkClk(linkClk),
		.linkRst_n(linkRst_n),
		.frameStart(startDet),
		.pinLevel(hiLkSync_reg[1]),
		.sclLevel(scl),
		.sdaLevel(sda),
		.level(hiLevel)
	);

	ipecd_sel_decode u_loSel (
		.linkClk(linkClk),
		.linkRst_n(linkRst_n),
		.frameStart(startDet),
		.pinLevel(loLkSync_reg[1]),
		.sclLevel(scl),
		.sdaLevel(sda),
		.level(loLevel)
	);

	assign selBits = {hiCode(hiLevel), loCode(loLevel)}; // [RULE_20]
	logic [7:0] shift_reg;
	assign matchA = (shift_reg[7:1] == {`IPECD_GRPA_PREFIX, selBits}); // [RULE_19]
	assign matchB = (shift_reg[7:1] == {`IPECD_GRPB_PREFIX, selBits}); // [RULE_19]

	// ----------------------------------------
	// Link domain: reply capture
	// ----------------------------------------
	logic [7:0] rply_reg;
	logic [7:0] txHold_reg;

	always_ff @(posedge linkClk) begin
		if (!linkRst_n) begin
			txHold_reg <= 8'h00;
		end else if (rplSync_reg[1] != rplPrev_reg) begin
			txHold_reg <= rply_reg;
		end
	end

	// ----------------------------------------
	// Link domain: protocol state machine
	// ----------------------------------------
	ipecd_pkg::ipecd_lstate_t state_reg;
	ipecd_pkg::ipecd_req_t req_reg;
	logic reqTgl_reg;
	logic [3:0] bitCnt_reg;
	logic [7:0] txShift_reg;
	logic isRead_reg;
	logic grpB_reg;
	logic sdaLow_reg;
	logic engaged;

	assign engaged = (state_reg != ipecd_pkg::LK_IDLE) &&
		(state_reg != ipecd_pkg::LK_ADDR);

	always_ff @(posedge linkClk) begin
		if (!linkRst_n) begin
			state_reg <= ipecd_pkg::LK_IDLE;
			req_reg <= mkReq(ipecd_pkg::CMD_NONE, 1'b0, 8'h00);
			reqTgl_reg <= 1'b0;
			bitCnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			txShift_reg <= 8'h00;
			isRead_reg <= 1'b0;
			grpB_reg <= 1'b0;
			sdaLow_reg <= 1'b0;
		end else if (startDet || stopDet) begin
			if (engaged) begin
				req_reg <= mkReq(ipecd_pkg::CMD_STOP, grpB_reg, 8'h00); // [RULE_07]
				reqTgl_reg <= ~reqTgl_reg;
			end
			state_reg <= startDet ? ipecd_pkg::LK_ADDR : ipecd_pkg::LK_IDLE; // [RULE_13]
			bitCnt_reg <= 4'h0;
			sdaLow_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ipecd_pkg::LK_IDLE, ipecd_pkg::LK_WAIT: begin
					sdaLow_reg <= 1'b0;
				end
				ipecd_pkg::LK_ADDR, ipecd_pkg::LK_RX: begin
					if (sclRise) begin
						shift_reg <= {shift_reg[6:0], sda}; // [RULE_15]
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end else if (sclFall && bitCnt_reg == `IPECD_BYTE_BITS) begin
						if (state_reg == ipecd_pkg::LK_RX) begin
							sdaLow_reg <= 1'b1; // [RULE_17]
							state_reg <= ipecd_pkg::LK_RACK;
						end else if (matchA || matchB) begin // [RULE_18]
							sdaLow_reg <= 1'b1; // [RULE_16]
							isRead_reg <= shift_reg[0];
							grpB_reg <= matchB;
							state_reg <= ipecd_pkg::LK_AACK;
						end else begin
							state_reg <= ipecd_pkg::LK_IDLE;
						end
					end
				end
				ipecd_pkg::LK_AACK: begin
					if (sclRise) begin
						req_reg <= mkReq(isRead_reg ? ipecd_pkg::CMD_ADDR_RD :
							ipecd_pkg::CMD_ADDR_WR, grpB_reg, 8'h00); // [RULE_02]
						reqTgl_reg <= ~reqTgl_reg;
					end else if (sclFall) begin
						bitCnt_reg <= 4'h0;
						if (isRead_reg) begin
							txShift_reg <= txHold_reg;
							sdaLow_reg <= ~txHold_reg[7];
							state_reg <= ipecd_pkg::LK_TX;
						end else begin
							sdaLow_reg <= 1'b0;
							state_reg <= ipecd_pkg::LK_RX;
						end
					end
				end
				ipecd_pkg::LK_RACK: begin
					if (sclRise) begin
						req_reg <= mkReq(ipecd_pkg::CMD_WRITE, grpB_reg,
							shift_reg); // [RULE_23]
						reqTgl_reg <= ~reqTgl_reg;
					end else if (sclFall) begin
						sdaLow_reg <= 1'b0;
						bitCnt_reg <= 4'h0;
						state_reg <= ipecd_pkg::LK_RX;
					end
				end
				ipecd_pkg::LK_TX: begin
					if (sclRise) begin
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end else if (sclFall) begin
						if (bitCnt_reg == `IPECD_BYTE_BITS) begin
							sdaLow_reg <= 1'b0; // [RULE_17]
							state_reg <= ipecd_pkg::LK_MACK;
						end else begin
							txShift_reg <= {txShift_reg[6:0], 1'b0};
							sdaLow_reg <= ~txShift_reg[6]; // [RULE_11]
						end
					end
				end
				ipecd_pkg::LK_MACK: begin
					if (sclRise) begin
						if (!sda) begin
							req_reg <= mkReq(ipecd_pkg::CMD_NEXT, grpB_reg,
								8'h00); // [RULE_04]
							reqTgl_reg <= ~reqTgl_reg;
						end else begin
							state_reg <= ipecd_pkg::LK_WAIT; // [RULE_24]
						end
					end else if (sclFall) begin
						bitCnt_reg <= 4'h0;
						txShift_reg <= txHold_reg;
						sdaLow_reg <= ~txHold_reg[7];
						state_reg <= ipecd_pkg::LK_TX;
					end
				end
			endcase
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOeN = ~sdaLow_reg; // [RULE_11]

	// ----------------------------------------
	// Port domain: synchronisers
	// ----------------------------------------
	logic [1:0] reqSync_reg;
	logic reqPrev_reg;
	logic [3:0] inMeta_reg;
	logic [3:0] inLive_reg;
	logic [3:0] pinAMeta_reg;
	logic [3:0] pinALive_reg;
	logic [7:0] pinBMeta_reg;
	logic [7:0] pinBLive_reg;
	logic [1:0] hiSync_reg;
	logic [1:0] loSync_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reqSync_reg <= 2'h0;
			reqPrev_reg <= 1'b0;
			inMeta_reg <= 4'h0;
			inLive_reg <= 4'h0;
			pinAMeta_reg <= 4'h0;
			pinALive_reg <= 4'h0;
			pinBMeta_reg <= 8'h00;
			pinBLive_reg <= 8'h00;
			hiSync_reg <= 2'h0;
			loSync_reg <= 2'h0;
		end else begin
			reqSync_reg <= {reqSync_reg[0], reqTgl_reg};
			reqPrev_reg <= reqSync_reg[1];
			inMeta_reg <= monitoredInputs;
			inLive_reg <= inMeta_reg;
			pinAMeta_reg <= groupAPinLevel;
			pinALive_reg <= pinAMeta_reg;
			pinBMeta_reg <= groupBPinLevel;
			pinBLive_reg <= pinBMeta_reg;
			hiSync_reg <= {hiSync_reg[0], addrSelHighPin};
			loSync_reg <= {loSync_reg[0], addrSelLowPin};
		end
	end

	// ----------------------------------------
	// Port domain: request decode
	// ----------------------------------------
	logic reqEv;
	logic isAddr;
	logic relatch;
	logic phase_reg;

	assign reqEv = reqSync_reg[1] ^ reqPrev_reg;
	assign isAddr = (req_reg.cmd == ipecd_pkg::CMD_ADDR_RD) ||
		(req_reg.cmd == ipecd_pkg::CMD_ADDR_WR);
	assign relatch = reqEv && (isAddr || (req_reg.cmd ==
		ipecd_pkg::CMD_NEXT && !req_reg.grpB && phase_reg)); // [RULE_04]

	// ----------------------------------------
	// Port domain: snapshot and change flags
	// ----------------------------------------
	logic [3:0] snap_reg;
	logic [3:0] flags_reg;
	logic [3:0] prevFlags_reg;
	logic [3:0] diff;

	assign diff = snap_reg ^ inLive_reg; // [RULE_01]

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			snap_reg <= 4'h0;
			flags_reg <= 4'h0;
			prevFlags_reg <= 4'h0;
		end else if (relatch) begin
			snap_reg <= inLive_reg; // [RULE_02]
			prevFlags_reg <= flags_reg | diff; // [RULE_03]
			flags_reg <= 4'h0;
		end else begin
			flags_reg <= flags_reg | diff; // [RULE_06] [RULE_09]
		end
	end

	// ----------------------------------------
	// Port domain: outputs, mask and strap
	// ----------------------------------------
	logic [3:0] mask_reg;
	logic [3:0] outA_reg;
	logic [7:0] outB_reg;
	logic [1:0] strapCnt_reg;
	logic strapDone_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			strapCnt_reg <= 2'h0;
			strapDone_reg <= 1'b0;
		end else if (!strapDone_reg) begin
			strapCnt_reg <= strapCnt_reg + 2'h1;
			strapDone_reg <= (strapCnt_reg == `IPECD_STRAP_WAIT);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mask_reg <= `IPECD_MASK_RST;
			outA_reg <= `IPECD_OUTA_RST;
			outB_reg <= `IPECD_OUTB_RST;
		end else if (reqEv && req_reg.cmd == ipecd_pkg::CMD_WRITE) begin
			if (req_reg.grpB) begin
				outB_reg <= req_reg.data; // [RULE_27]
			end else begin
				outA_reg <= {req_reg.data[7:6], req_reg.data[1:0]}; // [RULE_23]
				mask_reg <= req_reg.data[`IPECD_IN_MSB:`IPECD_IN_LSB]; // [RULE_10]
			end
		end else if (!strapDone_reg && strapCnt_reg == `IPECD_STRAP_WAIT) begin
			outB_reg <= {hiSync_reg[1] ? `IPECD_NIB_HI : `IPECD_NIB_LO,
				loSync_reg[1] ? `IPECD_NIB_HI : `IPECD_NIB_LO}; // [RULE_21]
		end
	end

	// ----------------------------------------
	// Port domain: reply bytes
	// ----------------------------------------
	logic readBusy_reg;
	logic [7:0] dataA;
	logic [7:0] flagByte;

	assign dataA = {pinALive_reg[3:2], inLive_reg, pinALive_reg[1:0]}; // [RULE_27]
	assign flagByte = {2'h0, prevFlags_reg, 2'h0}; // [RULE_10]

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rply_reg <= 8'h00;
			rplTgl_reg <= 1'b0;
			phase_reg <= 1'b0;
		end else if (reqEv && (req_reg.cmd == ipecd_pkg::CMD_ADDR_RD ||
			req_reg.cmd == ipecd_pkg::CMD_NEXT)) begin
			rplTgl_reg <= ~rplTgl_reg;
			if (req_reg.grpB) begin
				rply_reg <= pinBLive_reg; // [RULE_25]
			end else if (req_reg.cmd == ipecd_pkg::CMD_ADDR_RD || phase_reg) begin
				rply_reg <= dataA;
				phase_reg <= 1'b0;
			end else begin
				rply_reg <= flagByte; // [RULE_03]
				phase_reg <= 1'b1;
			end
		end else if (reqEv && isAddr) begin
			phase_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Port domain: interrupt
	// ----------------------------------------
	logic int_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			readBusy_reg <= 1'b0;
		end else if (reqEv && req_reg.cmd == ipecd_pkg::CMD_ADDR_RD) begin
			readBusy_reg <= 1'b1; // [RULE_07]
		end else if (reqEv && (req_reg.cmd == ipecd_pkg::CMD_STOP ||
			req_reg.cmd == ipecd_pkg::CMD_ADDR_WR)) begin
			readBusy_reg <= 1'b0; // [RULE_07]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			int_reg <= 1'b0;
		end else if (relatch) begin
			int_reg <= 1'b0; // [RULE_22] [RULE_08]
		end else begin
			int_reg <= (|(flags_reg & mask_reg)) && !readBusy_reg; // [RULE_05] [RULE_26]
		end
	end

	assign intOut = 1'b0;
	assign intOeN = ~int_reg;
	assign groupAOut = outA_reg;
	assign outputGroupB = outB_reg;
	assign changeFlags = flags_reg;
	assign interruptMask = mask_reg;

endmodule

// ### tb/ipecd_core_assertions.sv
// Concurrent checks on the port expander core ports
`timescale 1ns/1ps
module ipecd_core_assertions (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic linkClk,
	input wire logic linkRst_n,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOeN,
	input wire logic intOut,
	input wire logic intOeN,
	input wire logic addrSelHighPin,
	input wire logic addrSelLowPin,
	input wire logic [3:0] monitoredInputs,
	input wire logic [3:0] groupAPinLevel,
	input wire logic [7:0] groupBPinLevel,
	input wire logic [3:0] groupAOut,
	input wire logic [7:0] outputGroupB,
	input wire logic [3:0] changeFlags,
	input wire logic [3:0] interruptMask
);
	logic [7:0] idle_reg;
	logic [3:0] lastIn_reg;
	logic [3:0] sinceIn_reg;
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !(sclIn && sdaIn)) idle_reg <= 8'h00;
		else if (idle_reg != 8'hFF) idle_reg <= idle_reg + 8'h01;
	end
	always_ff @(posedge sys_clk) lastIn_reg <= monitoredInputs;
	always_ff @(posedge sys_clk) begin
		if (!rst_n || lastIn_reg != monitoredInputs) sinceIn_reg <= 4'h0;
		else if (sinceIn_reg != 4'hF) sinceIn_reg <= sinceIn_reg + 4'h1;
	end
	sequence rstSettled;
		$rose(rst_n) ##5 1'b1;
	endsequence
	sda_open_drain_a: assert property (@(posedge linkClk)
		disable iff (!linkRst_n) sdaOut == 1'b0)
		else $error("data driven high");
	sda_scl_low_a: assert property (@(posedge linkClk)
		disable iff (!linkRst_n) $changed(sdaOeN) |-> !sclIn)
		else $error("data moved in clock high");
	int_cause_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n) $fell(intOeN) |->
		|($past(changeFlags) & $past(interruptMask))) else $error("int no cause");
	int_pending_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n) idle_reg > 8'h40 && |(changeFlags & interruptMask)
		|-> ##2 !intOeN) else $error("int missing");
	int_release_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n) $rose(intOeN) |-> idle_reg == 8'h00)
		else $error("int released idle");
	flag_cause_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n) |(changeFlags & ~$past(changeFlags))
		|-> sinceIn_reg < 4'h8) else $error("flag without change");
	flag_hold_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n) |($past(changeFlags) & ~changeFlags)
		|-> idle_reg == 8'h00) else $error("flag cleared idle");
	strap_init_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n) rstSettled |->
		outputGroupB == {{4{addrSelHighPin}}, {4{addrSelLowPin}}})
		else $error("strap wrong");
endmodule

// ### tb/ipecd_master_model.sv
// Two-wire bus master model
`timescale 1ns/1ps
module ipecd_master_model (
	output logic scl,
	output logic sdaRel,
	input wire logic sdaW,
	output logic [7:0] rxData,
	output logic rxTgl
);
	initial begin
		scl = 1'b1;
		sdaRel = 1'b1;
		rxData = 8'h00;
		rxTgl = 1'b0;
	end
	task automatic bitC(input logic b, output logic r);
		sdaRel = b;
		#200;
		scl = 1'b1;
		#400;
		r = sdaW;
		scl = 1'b0;
		#200;
	endtask
	task automatic startC();
		sdaRel = 1'b0;
		#200;
		scl = 1'b0;
		#200;
	endtask
	task automatic stopC();
		sdaRel = 1'b0;
		#200;
		scl = 1'b1;
		#200;
		sdaRel = 1'b1;
		#400;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic nack,
		input logic rd, output logic ack);
		logic [7:0] r;
		for (int i = 7; i >= 0; i--) bitC(tx[i], r[i]);
		bitC(nack, ack);
		if (rd) begin
			rxData = r;
			rxTgl = ~rxTgl;
		end
	endtask
endmodule

// ### tb/i2c_port_expander_change_detect_tb_top.sv
// Top testbench for the port expander core
`timescale 1ns/1ps
module i2c_port_expander_change_detect_tb_top;
	logic sys_clk, rst_n, linkClk, linkRst_n, sclIn, sdaIn, sdaOut, sdaOeN;
	logic intOut, intOeN, addrSelHighPin, addrSelLowPin, sdaRel, rxTgl, ack;
	logic [3:0] monitoredInputs, groupAPinLevel, groupAOut;
	logic [3:0] changeFlags, interruptMask;
	logic [7:0] groupBPinLevel, outputGroupB, bForce, wb, rxData, bOld;
	logic [7:0] expQ[$];
	int errorCnt = 0;
	int compares = 0;
	assign sdaIn = sdaRel & (sdaOeN | sdaOut);
	assign addrSelLowPin = sdaIn;
	assign groupAPinLevel = groupAOut;
	assign groupBPinLevel = outputGroupB ^ bForce;
	ipecd_core u_dut (.sys_clk, .rst_n, .linkClk, .linkRst_n, .sclIn, .sdaIn,
		.sdaOut, .sdaOeN, .intOut, .intOeN, .addrSelHighPin, .addrSelLowPin,
		.monitoredInputs, .groupAPinLevel, .groupBPinLevel, .groupAOut,
		.outputGroupB, .changeFlags, .interruptMask);
	ipecd_master_model u_m (.scl(sclIn), .sdaRel, .sdaW(sdaIn), .rxData,
		.rxTgl);
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		linkClk = 1'b0;
		#3;
		forever #16 linkClk = ~linkClk;
	end
	task automatic chk(input logic [7:0] e, input logic [7:0] a);
		compares++;
		if (a !== e) begin
			errorCnt++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d compares=%0d", errorCnt, compares);
		if (errorCnt == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic setIn(input logic [3:0] v);
		@(posedge sys_clk);
		#1 monitoredInputs = v;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic waitIntLow();
		int n;
		n = 0;
		while (intOeN !== 1'b0 && n < 30) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 30) begin
			errorCnt++;
			tally_and_finish();
		end
	endtask
	task automatic frame(input logic [6:0] a, input logic rd);
		u_m.startC();
		u_m.xfer({a, rd}, 1'b1, 1'b0, ack);
	endtask
	task automatic rdB(input logic [7:0] e, input logic nack);
		expQ.push_back(e);
		u_m.xfer(8'hFF, nack, 1'b1, ack);
	endtask
	always @(rxTgl) begin
		if ($time > 0) chk(expQ.size() ? expQ.pop_front() : ~rxData, rxData);
	end
	initial begin
		#500000;
		errorCnt++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(74));
		rst_n = 1'b0;
		linkRst_n = 1'b0;
		addrSelHighPin = 1'b0;
		monitoredInputs = 4'h0;
		bForce = 8'h00;
		repeat (4) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge linkClk);
		#1 linkRst_n = 1'b1;
		repeat (20) @(posedge sys_clk);
		chk(8'h0F, outputGroupB);
		frame(7'h6A, 1'b0);
		u_m.stopC();
		chk(8'h01, {7'h0, ack});
		setIn(4'($urandom()));
		wb = 8'($urandom());
		frame(7'h6B, 1'b0);
		chk(8'h00, {7'h0, ack});
		u_m.xfer(wb, 1'b1, 1'b0, ack);
		wb[5:2] = 4'h5;
		u_m.xfer(wb, 1'b1, 1'b0, ack);
		chk(8'h00, {7'h0, ack});
		u_m.stopC();
		chk({4'h0, wb[7:6], wb[1:0]}, {4'h0, groupAOut});
		chk(8'h05, {4'h0, interruptMask});
		setIn(monitoredInputs ^ 4'h1);
		waitIntLow();
		chk(8'h01, {4'h0, changeFlags});
		setIn(monitoredInputs ^ 4'h2);
		setIn(monitoredInputs ^ 4'h2);
		chk(8'h03, {4'h0, changeFlags});
		frame(7'h6B, 1'b1);
		chk(8'h01, {7'h0, intOeN});
		rdB({wb[7:6], monitoredInputs, wb[1:0]}, 1'b0);
		setIn(monitoredInputs ^ 4'h1);
		chk(8'h01, {7'h0, intOeN});
		rdB(8'h0C, 1'b0);
		rdB({wb[7:6], monitoredInputs, wb[1:0]}, 1'b0);
		rdB(8'h04, 1'b1);
		u_m.stopC();
		chk(8'h01, {7'h0, intOeN});
		frame(7'h6B, 1'b1);
		rdB({wb[7:6], monitoredInputs, wb[1:0]}, 1'b1);
		setIn(monitoredInputs ^ 4'h4);
		chk(8'h01, {7'h0, intOeN});
		u_m.stopC();
		waitIntLow();
		chk(8'h04, {4'h0, changeFlags});
		wb = 8'($urandom());
		frame(7'h5B, 1'b0);
		u_m.xfer(wb, 1'b1, 1'b0, ack);
		u_m.stopC();
		chk(wb, outputGroupB);
		chk(8'h01, {7'h0, intOeN});
		chk(8'h00, {4'h0, changeFlags});
		@(posedge sys_clk);
		#1 bForce = 8'($urandom());
		frame(7'h5B, 1'b1);
		bOld = bForce;
		@(posedge sys_clk);
		#1 bForce = 8'($urandom());
		rdB(wb ^ bOld, 1'b0);
		rdB(wb ^ bForce, 1'b1);
		u_m.stopC();
		addrSelHighPin = 1'b1;
		frame(7'h5B, 1'b0);
		u_m.stopC();
		chk(8'h01, {7'h0, ack});
		frame(7'h5F, 1'b0);
		u_m.stopC();
		chk(8'h00, {7'h0, ack});
		chk(8'h00, {6'h0, intOut, sdaOut});
		tally_and_finish();
	end
endmodule
bind ipecd_core ipecd_core_assertions u_chk (.sys_clk, .rst_n, .linkClk,
	.linkRst_n, .sclIn, .sdaIn, .sdaOut, .sdaOeN, .intOut, .intOeN,
	.addrSelHighPin, .addrSelLowPin, .monitoredInputs, .groupAPinLevel,
	.groupBPinLevel, .groupAOut, .outputGroupB, .changeFlags, .interruptMask);
